// >>> include/dsc_regs.vh
// constants for the dual serial channel register block
`ifndef DSC_REGS_VH
`define DSC_REGS_VH
// ==========================================================================
// i/o addresses
`define DSC_ADDR_A_DATA 8'h40
`define DSC_ADDR_B_DATA 8'h42
`define DSC_ADDR_A_CMD 8'h44
`define DSC_ADDR_B_CMD 8'h46
`define DSC_ADDR_BOARD 8'h80
`define DSC_ADDR_RING_CLR 8'hA0
// ==========================================================================
// board register bit positions
`define DSC_BIT_DTR_B 8
`define DSC_BIT_RING 9
`define DSC_BIT_DSR_A 10
`define DSC_BIT_CLKDRV 8
`define DSC_BIT_CLKSEL 9
// ==========================================================================
// indexed register numbers
`define DSC_IDX_CMD 3'h0
`define DSC_IDX_INTW 3'h1
`define DSC_IDX_VEC 3'h2
// ==========================================================================
// one-shot commands, bits 5..3 of the command register
`define DSC_CMD_ABORT 3'h1
`define DSC_CMD_EXT_RST 3'h2
`define DSC_CMD_CHAN_RST 3'h3
`define DSC_CMD_ARM_RX 3'h4
`define DSC_CMD_TXP_CLR 3'h5
`define DSC_CMD_ERR_RST 3'h6
`define DSC_CMD_EOI 3'h7
// resets, bits 7..6 of the command register
`define DSC_RST_RXCRC 2'h1
`define DSC_RST_TXCRC 2'h2
`define DSC_RST_EOM 2'h3
// ==========================================================================
// field positions inside indexed write registers
`define DSC_W1_EXT 0
`define DSC_W1_TX 1
`define DSC_W1_SAV 2
`define DSC_W1_WAIT_RX 5
`define DSC_W1_WAIT_EN 7
`define DSC_W2_PRIO 2
`define DSC_W2_PINSEL 7
`define DSC_W3_HUNT 4
`define DSC_W5_RTS 1
`define DSC_W5_TXEN 3
// ==========================================================================
// reset values
`define DSC_WREG_RST 8'h00
`define DSC_PTR_RST 3'h0
`define DSC_CTRL_RST 2'h0
`endif

// >>> core/dsc_regs.v
// register side of the two-channel serial controller and its board glue
`timescale 1ns/1ps
`include "dsc_regs.vh"

// Behaviour
// - ring latch shown on board bit 9
// - reading address A0 clears ring latch
// - dsr A bit 10, dtr B bit 8
// - control bit 9 picks timer or connector clock
// - control bit 8 gates equipment clocks, else high
// - four data and command/status ports decoded
// - command register low bits set pointer
// - pointer is zero after reset
// - command bits 5..3 run one-shot commands
// - command bits 7..6 run crc and eom resets
// - register 1 enables ext, tx, rx interrupts
// - status-affects-vector modifies vector readback
// - register 1 wait enable and direction
// - service mode and priority order
// - shared pin select, register 2 bit 7; bits 6..3 unused
// - receive control bits passed to receiver
// - parity and stop bit format fields
// - sync framing and clock multiplier fields
// - transmit control bits passed to transmitter
// - line buffer status bits reported
// - special receive status bits reported
module dsc_regs (
  input wire clk_i,
  input wire rst_i,
  // host i/o bus, same clock, one-cycle strobes
  input wire [7:0] io_addr_i,
  input wire io_rd_i,
  input wire io_wr_i,
  input wire [15:0] io_wdata_i,
  output reg [15:0] io_rdata_o,
  output reg io_rvalid_o,
  output reg irq_o,
  // modem pins, asynchronous
  input wire ring_i,
  input wire dsr_a_n_i,
  input wire dtr_b_n_i,
  input wire [1:0] cd_n_i,
  input wire [1:0] cts_n_i,
  input wire ext_clk_i,
  input wire timer_a_clk_i,
  input wire timer_b_clk_i,
  // clock outputs
  output reg term_clk_o,
  output reg term_clk_rise_o,
  output reg equip_txc_o,
  output reg equip_rxc_o,
  // receiver byte stream per channel
  input wire [1:0] rx_valid_i,
  input wire [15:0] rx_data_i,
  output reg [1:0] rx_ready_o,
  input wire [1:0] rx_parity_err_i,
  input wire [1:0] rx_frame_err_i,
  input wire [1:0] rx_break_i,
  // transmitter byte stream per channel
  output reg [1:0] tx_valid_o,
  output reg [15:0] tx_data_o,
  input wire [1:0] tx_ready_i,
  input wire [1:0] tx_underrun_i,
  // configuration and command strobes to the serial engines
  output reg [15:0] rx_ctl_o,
  output reg [15:0] fmt_o,
  output reg [15:0] tx_ctl_o,
  output reg [15:0] sync_byte_o,
  output reg [1:0] tx_enable_o,
  output reg [1:0] rts_n_o,
  output reg pin10_n_o,
  output reg [1:0] wait_o,
  output reg [1:0] dma_req_o,
  output reg [1:0] abort_o,
  output reg [1:0] rx_crc_rst_o,
  output reg [1:0] tx_crc_rst_o,
  output reg [1:0] chan_rst_o
);

  // ========================================================================
  // port decode: bit2 valid, bit1 command port, bit0 channel b
  function [2:0] dsc_port;
    input [7:0] a;
    begin
      case (a)
        `DSC_ADDR_A_DATA: dsc_port = 3'h4;
        `DSC_ADDR_B_DATA: dsc_port = 3'h5;
        `DSC_ADDR_A_CMD: dsc_port = 3'h6;
        `DSC_ADDR_B_CMD: dsc_port = 3'h7;
        default: dsc_port = 3'h0;
      endcase
    end
  endfunction

  // ========================================================================
  // pin synchronisers
  reg [9:0] meta_ff; // first stage, read only by sync_ff
  reg [9:0] sync_ff; // second stage, safe to use
  reg [9:0] prev_ff; // last value for edge and change detect
  wire [9:0] pins;
  assign pins = {timer_b_clk_i, timer_a_clk_i, ext_clk_i, cts_n_i, cd_n_i,
                 dtr_b_n_i, dsr_a_n_i, ring_i};

  // two flops before any logic sees a pin; kept running through reset so
  // the change detectors start from the idle pin level, not a false edge
  always @(posedge clk_i) begin
    meta_ff <= pins;
    sync_ff <= meta_ff;
    prev_ff <= sync_ff;
  end

  // ========================================================================
  // state
  reg [7:0] wreg_ff [0:15]; // indexed write registers, {channel, index}
  reg [2:0] ptr_ff [0:1]; // register pointer per channel
  reg [1:0] ctrl_ff; // board control: clock select, clock drive
  reg ring_ff; // latched ring indication
  reg [7:0] fifo_ff [0:3]; // two receive entries per channel
  reg [1:0] cnt_ff [0:1]; // entries held per channel
  reg [1:0] rd_sel_ff; // read slot per channel
  reg [1:0] wr_sel_ff; // write slot per channel
  reg [1:0] par_ff; // parity error latch
  reg [1:0] ovr_ff; // receive overrun latch
  reg [1:0] frm_ff; // crc or framing error latch
  reg [1:0] eom_ff; // transmit underrun / end-of-message latch
  reg [1:0] hunt_ff; // hunting for sync
  reg [1:0] ext_ff; // external status change pending
  reg [1:0] txp_ff; // transmit buffer empty interrupt pending
  reg [1:0] armed_ff; // first-character receive interrupt armed
  reg ins_ff; // an interrupt is in service
  integer c; // channel index of the main process
  integer s; // channel index of the status decode
  integer j; // channel index of the output process

  // ========================================================================
  // per-channel status and interrupt sources
  reg [7:0] rr0_w [0:1];
  reg [7:0] rr1_w [0:1];
  reg [3:0] src_w [0:1]; // {special, rx, tx, ext}
  reg [1:0] dma_w; // channel serviced by dma
  reg [1:0] rxm; // receive interrupt mode
  reg [2:0] cause_w; // vector low bits of the winning source
  reg any_w; // some enabled source is pending

  always @* begin
    dma_w[0] = (wreg_ff[2][1:0] == 2'h1) ||
               (wreg_ff[2][1:0] == 2'h2);
    dma_w[1] = (wreg_ff[2][1:0] == 2'h2);
    rxm = 2'h0;
    for (s = 0; s < 2; s = s + 1) begin
      // line buffer status: clear-to-send bit 5, carrier bit 3
      rr0_w[s] = {rx_break_i[s], eom_ff[s], ~sync_ff[5 + s],
                  hunt_ff[s], ~sync_ff[3 + s], ~tx_valid_o[s],
                  (s == 0) ? irq_o : 1'b0, cnt_ff[s] != 2'h0};
      // special receive status, no residue tracking here
      rr1_w[s] = {1'b0, frm_ff[s], ovr_ff[s], par_ff[s], 3'h0,
                  ~tx_valid_o[s]};
      rxm = wreg_ff[s * 8 + 1][4:3];
      // enables from register 1; dma channels raise no tx or rx interrupt
      src_w[s][0] = ext_ff[s] & wreg_ff[s * 8 + 1][`DSC_W1_EXT];
      src_w[s][1] = txp_ff[s] & wreg_ff[s * 8 + 1][`DSC_W1_TX] &
                    ~dma_w[s];
      src_w[s][2] = (rxm != 2'h0) && (cnt_ff[s] != 2'h0) &&
                    ((rxm != 2'h1) || armed_ff[s]) && !dma_w[s];
      src_w[s][3] = (rxm != 2'h0) && (par_ff[s] | ovr_ff[s] | frm_ff[s]);
    end
  end

  // priority: receivers first, or channel a first; external sources last either way
  always @* begin
    any_w = 1'b1;
    if (src_w[0][3]) cause_w = 3'h7;
    else if (src_w[0][2]) cause_w = 3'h6;
    else if (wreg_ff[2][`DSC_W2_PRIO] && src_w[1][3]) cause_w = 3'h3;
    else if (wreg_ff[2][`DSC_W2_PRIO] && src_w[1][2]) cause_w = 3'h2;
    else if (src_w[0][1]) cause_w = 3'h4;
    else if (src_w[1][3]) cause_w = 3'h3;
    else if (src_w[1][2]) cause_w = 3'h2;
    else if (src_w[1][1]) cause_w = 3'h0;
    else if (src_w[0][0]) cause_w = 3'h5; // external sources last
    else if (src_w[1][0]) cause_w = 3'h1;
    else begin
      cause_w = 3'h0;
      any_w = 1'b0;
    end
  end

  // ========================================================================
  // bus decode for this cycle
  wire [2:0] wport;
  wire [2:0] rport;
  wire [7:0] wb;
  assign wport = io_wr_i ? dsc_port(io_addr_i) : 3'h0;
  assign rport = io_rd_i ? dsc_port(io_addr_i) : 3'h0;
  assign wb = io_wdata_i[7:0];

  // vector readback, modified by cause when enabled in channel b
  wire [7:0] vec_w;
  assign vec_w = wreg_ff[9][`DSC_W1_SAV] ?
                 {wreg_ff[10][7:3], cause_w} : wreg_ff[10];

  // read data from an indexed read register
  reg [7:0] idx_rd;
  reg rch;
  always @* begin
    rch = rport[0];
    case (ptr_ff[rch])
      3'h0: idx_rd = rr0_w[rch];
      3'h1: idx_rd = rr1_w[rch];
      3'h2: idx_rd = rch ? vec_w : 8'h00;
      default: idx_rd = 8'h00; // unimplemented read index
    endcase
  end

  // ========================================================================
  // main clocked process
  always @(posedge clk_i) begin
    if (rst_i) begin
      for (c = 0; c < 16; c = c + 1) begin
        wreg_ff[c] <= `DSC_WREG_RST; // contents undefined to software
      end
      for (c = 0; c < 4; c = c + 1) begin
        fifo_ff[c] <= 8'h00;
      end
      ptr_ff[0] <= `DSC_PTR_RST;
      ptr_ff[1] <= `DSC_PTR_RST;
      cnt_ff[0] <= 2'h0;
      cnt_ff[1] <= 2'h0;
      ctrl_ff <= `DSC_CTRL_RST;
      ring_ff <= 1'b0;
      rd_sel_ff <= 2'h0;
      wr_sel_ff <= 2'h0;
      par_ff <= 2'h0;
      ovr_ff <= 2'h0;
      frm_ff <= 2'h0;
      eom_ff <= 2'h0;
      hunt_ff <= 2'h0;
      ext_ff <= 2'h0;
      txp_ff <= 2'h0;
      armed_ff <= 2'h0;
      ins_ff <= 1'b0;
      io_rdata_o <= 16'h0000;
      io_rvalid_o <= 1'b0;
      irq_o <= 1'b0;
      rx_ready_o <= 2'h0;
      tx_valid_o <= 2'h0;
      tx_data_o <= 16'h0000;
      abort_o <= 2'h0;
      rx_crc_rst_o <= 2'h0;
      tx_crc_rst_o <= 2'h0;
      chan_rst_o <= 2'h0;
    end else begin
      // one-cycle strobes default low
      abort_o <= 2'h0;
      rx_crc_rst_o <= 2'h0;
      tx_crc_rst_o <= 2'h0;
      chan_rst_o <= 2'h0;
      io_rvalid_o <= io_rd_i;
      // ring latch: set wins over the clearing read
      ring_ff <= sync_ff[0] | (ring_ff &
                 !(io_rd_i && io_addr_i == `DSC_ADDR_RING_CLR));
      // board control write keeps only the two clock bits
      if (io_wr_i && io_addr_i == `DSC_ADDR_BOARD) begin
        ctrl_ff <= {io_wdata_i[`DSC_BIT_CLKSEL], io_wdata_i[`DSC_BIT_CLKDRV]};
      end
      // read data mux, unmapped addresses read zero
      if (io_rd_i) begin
        if (io_addr_i == `DSC_ADDR_BOARD) begin
          io_rdata_o <= 16'h0000;
          io_rdata_o[`DSC_BIT_RING] <= ring_ff;
          io_rdata_o[`DSC_BIT_DSR_A] <= sync_ff[1];
          io_rdata_o[`DSC_BIT_DTR_B] <= sync_ff[2];
        end else if (rport[2] && rport[1]) begin
          io_rdata_o <= {8'h00, idx_rd};
        end else if (rport[2]) begin
          // buffer slot is {channel, read slot}
          io_rdata_o <= (cnt_ff[rport[0]] != 2'h0) ?
                        {8'h00, fifo_ff[{rport[0], rd_sel_ff[rport[0]]}]} :
                        16'h0000;
        end else begin
          io_rdata_o <= 16'h0000;
        end
      end
      // interrupt request held off while one is in service
      irq_o <= any_w & ~ins_ff;
      // reading the vector through channel b enters service
      if (rport == 3'h7 && ptr_ff[1] == `DSC_IDX_VEC && irq_o) begin
        ins_ff <= 1'b1;
      end
      for (c = 0; c < 2; c = c + 1) begin
        // receive buffer: push from receiver, pop by data port read
        if (rx_valid_i[c] && rx_ready_o[c]) begin
          fifo_ff[{c[0], wr_sel_ff[c]}] <= rx_data_i[c * 8 +: 8];
          wr_sel_ff[c] <= ~wr_sel_ff[c];
          hunt_ff[c] <= 1'b0;
        end
        if (rport == {2'h2, c[0]} && cnt_ff[c] != 2'h0) begin
          rd_sel_ff[c] <= ~rd_sel_ff[c];
          armed_ff[c] <= 1'b0;
        end
        cnt_ff[c] <= cnt_ff[c] + {1'b0, rx_valid_i[c] & rx_ready_o[c]} -
                     {1'b0, rport == {2'h2, c[0]} && cnt_ff[c] != 2'h0};
        rx_ready_o[c] <= (cnt_ff[c] + {1'b0, rx_valid_i[c] &
                         rx_ready_o[c]} - {1'b0, rport == {2'h2, c[0]} &&
                         cnt_ff[c] != 2'h0}) < 2'h2;
        // error latches: events set over the error reset
        par_ff[c] <= par_ff[c] | (rx_valid_i[c] & rx_ready_o[c] &
                     rx_parity_err_i[c]);
        frm_ff[c] <= frm_ff[c] | (rx_valid_i[c] & rx_ready_o[c] &
                     rx_frame_err_i[c]);
        ovr_ff[c] <= ovr_ff[c] | (rx_valid_i[c] & ~rx_ready_o[c]);
        // external status change: carrier, clear-to-send, break
        ext_ff[c] <= ext_ff[c] | (sync_ff[3 + c] != prev_ff[3 + c]) |
                     (sync_ff[5 + c] != prev_ff[5 + c]) | rx_break_i[c];
        eom_ff[c] <= eom_ff[c] | tx_underrun_i[c];
        // transmit holding register; pending set as it empties
        if (tx_valid_o[c] && tx_ready_i[c]) begin
          tx_valid_o[c] <= 1'b0;
          txp_ff[c] <= 1'b1;
        end
        if (wport == {2'h2, c[0]}) begin
          tx_valid_o[c] <= 1'b1; // a write while full replaces the byte
          tx_data_o[c * 8 +: 8] <= wb;
          txp_ff[c] <= 1'b0;
        end
        // command/status port write
        if (wport == {2'h3, c[0]}) begin
          if (ptr_ff[c] == `DSC_IDX_CMD) begin
            ptr_ff[c] <= wb[2:0];
            case (wb[5:3])
              `DSC_CMD_ABORT: abort_o[c] <= 1'b1;
              `DSC_CMD_EXT_RST: begin
                // a change in this very cycle survives the reset
                ext_ff[c] <= (sync_ff[3 + c] != prev_ff[3 + c]) |
                             (sync_ff[5 + c] != prev_ff[5 + c]) |
                             rx_break_i[c];
              end
              `DSC_CMD_CHAN_RST: begin
                chan_rst_o[c] <= 1'b1;
                cnt_ff[c] <= 2'h0;
                rx_ready_o[c] <= 1'b1;
                rd_sel_ff[c] <= 1'b0;
                wr_sel_ff[c] <= 1'b0;
                {par_ff[c], ovr_ff[c], frm_ff[c]} <= 3'h0;
                {eom_ff[c], ext_ff[c], txp_ff[c]} <= 3'h0;
                tx_valid_o[c] <= 1'b0;
                armed_ff[c] <= 1'b0;
                ptr_ff[c] <= `DSC_PTR_RST;
              end
              `DSC_CMD_ARM_RX: armed_ff[c] <= 1'b1;
              `DSC_CMD_TXP_CLR: txp_ff[c] <= tx_valid_o[c] & tx_ready_i[c];
              `DSC_CMD_ERR_RST: begin
                par_ff[c] <= rx_valid_i[c] & rx_ready_o[c] &
                             rx_parity_err_i[c];
                frm_ff[c] <= rx_valid_i[c] & rx_ready_o[c] &
                             rx_frame_err_i[c];
                ovr_ff[c] <= rx_valid_i[c] & ~rx_ready_o[c];
              end
              `DSC_CMD_EOI: ins_ff <= 1'b0;
              default: ; // null code
            endcase
            case (wb[7:6])
              `DSC_RST_RXCRC: rx_crc_rst_o[c] <= 1'b1;
              `DSC_RST_TXCRC: tx_crc_rst_o[c] <= 1'b1;
              `DSC_RST_EOM: eom_ff[c] <= tx_underrun_i[c];
              default: ; // null code
            endcase
          end else begin
            wreg_ff[{c[0], ptr_ff[c]}] <= wb;
            ptr_ff[c] <= `DSC_PTR_RST;
            if (ptr_ff[c] == 3'h3 && wb[`DSC_W3_HUNT]) begin
              hunt_ff[c] <= 1'b1; // enter hunt
            end
          end
        end
        // pointer returns to zero after a non-zero indexed read
        if (rport == {2'h3, c[0]} && ptr_ff[c] != `DSC_PTR_RST) begin
          ptr_ff[c] <= `DSC_PTR_RST;
        end
      end
    end
  end

  // ========================================================================
  // configuration outputs, clocks, wait and shared pin
  always @(posedge clk_i) begin
    if (rst_i) begin
      rx_ctl_o <= 16'h0000;
      fmt_o <= 16'h0000;
      tx_ctl_o <= 16'h0000;
      sync_byte_o <= 16'h0000;
      tx_enable_o <= 2'h0;
      rts_n_o <= 2'h3;
      pin10_n_o <= 1'b1;
      wait_o <= 2'h0;
      dma_req_o <= 2'h0;
      term_clk_o <= 1'b0;
      term_clk_rise_o <= 1'b0;
      equip_txc_o <= 1'b1;
      equip_rxc_o <= 1'b1;
    end else begin
      rx_ctl_o <= {wreg_ff[11], wreg_ff[3]};
      fmt_o <= {wreg_ff[12], wreg_ff[4]};
      tx_ctl_o <= {wreg_ff[13], wreg_ff[5]};
      sync_byte_o <= {wreg_ff[14], wreg_ff[6]};
      tx_enable_o <= {wreg_ff[13][`DSC_W5_TXEN], wreg_ff[5][`DSC_W5_TXEN]};
      rts_n_o <= ~{wreg_ff[13][`DSC_W5_RTS], wreg_ff[5][`DSC_W5_RTS]};
      // shared pin: sync detect or request-to-send of channel b
      pin10_n_o <= wreg_ff[2][`DSC_W2_PINSEL] ? hunt_ff[1] :
                   ~wreg_ff[13][`DSC_W5_RTS];
      for (j = 0; j < 2; j = j + 1) begin
        // wait on receive: no byte; wait on transmit: buffer full
        wait_o[j] <= wreg_ff[j * 8 + 1][`DSC_W1_WAIT_EN] &
                     (wreg_ff[j * 8 + 1][`DSC_W1_WAIT_RX] ?
                      (cnt_ff[j] == 2'h0) : tx_valid_o[j]);
        dma_req_o[j] <= dma_w[j] & ((cnt_ff[j] != 2'h0) |
                        (~tx_valid_o[j] & txp_ff[j]));
      end
      // terminal-side clock: connector or timer, edge found here
      term_clk_o <= ctrl_ff[1] ? sync_ff[8] : sync_ff[7];
      term_clk_rise_o <= ctrl_ff[1] ? (sync_ff[8] & ~prev_ff[8]) :
                         (sync_ff[7] & ~prev_ff[7]);
      // equipment-side drivers hold high while disabled
      equip_txc_o <= ctrl_ff[0] ? sync_ff[9] : 1'b1;
      equip_rxc_o <= ctrl_ff[0] ? sync_ff[9] : 1'b1;
    end
  end

endmodule

// >>> verification/dsc_regs_asserts.sv
// port-level checks for the register block
`timescale 1ns/1ps
module dsc_regs_asserts (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] io_addr_i,
  input wire logic io_rd_i,
  input wire logic io_wr_i,
  input wire logic [15:0] io_wdata_i,
  input wire logic [15:0] io_rdata_o,
  input wire logic io_rvalid_o,
  input wire logic equip_txc_o,
  input wire logic equip_rxc_o,
  input wire logic [1:0] tx_valid_o,
  input wire logic [1:0] tx_ready_i,
  input wire logic [1:0] rts_n_o,
  input wire logic pin10_n_o,
  input wire logic [1:0] rx_ready_o,
  input wire logic [1:0] abort_o
);
  // ==========================================================
  // bus answer timing
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_read_answer: assert property (io_rd_i |=> io_rvalid_o)
    else $error("read not answered next cycle");
  a_answer_cause: assert property (io_rvalid_o |-> $past(io_rd_i))
    else $error("answer without a read");
  a_rdata_hold: assert property (!io_rvalid_o |-> $stable(io_rdata_o))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (io_rd_i && io_addr_i == 8'h10
    |=> io_rdata_o == 16'h0000) else $error("unmapped read not zero");
  // ==========================================================
  // clock gating, streams and pulses
  a_clk_gate_off: assert property (io_wr_i && io_addr_i == 8'h80
    && !io_wdata_i[8] |-> ##4 (equip_txc_o && equip_rxc_o) [*4])
    else $error("equipment clocks not held high");
  a_tx_launch: assert property (io_wr_i && io_addr_i == 8'h40
    |=> tx_valid_o[0]) else $error("transmit byte not offered");
  a_tx_hold: assert property (tx_valid_o[0] && !tx_ready_i[0]
    |=> tx_valid_o[0]) else $error("transmit byte dropped in stall");
  a_abort_pulse: assert property (abort_o[0] |=> !abort_o[0])
    else $error("abort pulse longer than one cycle");
  a_reset_idle: assert property (disable iff (1'b0) rst_i |=>
    rts_n_o == 2'h3 && pin10_n_o && rx_ready_o == 2'h0)
    else $error("outputs not idle in reset");
endmodule

// >>> verification/dsc_far_model.sv
// far-side line equipment: byte source, stalling sink, link clocks
`timescale 1ns/1ps
module dsc_far_model (
  input wire logic clk_i,
  input wire logic run_i,
  input wire logic stall_i,
  input wire logic [1:0] rx_ready_i,
  input wire logic [1:0] tx_valid_i,
  input wire logic [15:0] tx_data_i,
  output logic [1:0] rx_valid_o,
  output logic [15:0] rx_data_o,
  output logic [1:0] tx_ready_o,
  output logic ext_clk_o,
  output logic timer_clk_o,
  output logic [7:0] last_tx_o
);
  initial begin
    rx_valid_o = 2'h0;
    rx_data_o = 16'hA5A5;
    tx_ready_o = 2'h0;
    ext_clk_o = 1'b1;
    timer_clk_o = 1'b0;
    last_tx_o = 8'h00;
  end
  // 32 ns clocks; the connector clock stands still outside frames
  always #16 timer_clk_o = ~timer_clk_o;
  always #16 if (run_i) ext_clk_o = ~ext_clk_o;
  // sink takes a byte on valid and ready, stalls on request
  always @(posedge clk_i) begin
    tx_ready_o <= stall_i ? 2'h0 : 2'h3;
    if (tx_valid_i[0] && tx_ready_o[0]) last_tx_o <= tx_data_i[7:0];
  end
  // source holds until ready unless told to force a lost byte
  task push(input logic [7:0] b, input logic hold);
    int k;
    k = 0;
    @(posedge clk_i);
    rx_valid_o <= 2'h1;
    rx_data_o <= {~b, b};
    do begin
      @(posedge clk_i);
      k++;
    end while (hold && rx_ready_i[0] !== 1'b1 && k < 100);
    rx_valid_o <= 2'h0;
    rx_data_o <= {b, ~b}; // released lane shows no stale byte
  endtask
endmodule

// >>> verification/tb_top.sv
// self-checking bench for the register block
`timescale 1ns/1ps
module tb_top;
  logic clk_i = 0, rst_i = 1, io_rd_i = 0, io_wr_i = 0, run = 0, stall = 0;
  logic ring_i = 0, dsr_a_n_i = 0, dtr_b_n_i = 1;
  logic [1:0] cd_n_i = 2'h2, cts_n_i = 2'h1;
  logic [7:0] io_addr_i = 8'h00, last_tx;
  logic [15:0] io_wdata_i = 16'h0000, io_rdata_o, rx_data_i, tx_data_o;
  logic [15:0] rx_ctl_o, fmt_o, tx_ctl_o, got, sb;
  logic [1:0] wt_o;
  logic [1:0] rx_valid_i, rx_ready_o, tx_valid_o, tx_ready_i, tx_enable_o;
  logic [1:0] rts_n_o, abort_o, rx_crc_rst_o, tx_crc_rst_o, chan_rst_o;
  logic io_rvalid_o, irq_o, ext_clk_i, tclk, term_clk_o, term_clk_rise_o;
  logic equip_txc_o, equip_rxc_o, pin10_n_o;
  int fails = 0, tests_run = 0, rises = 0, lows = 0, n, k;
  int pc[4] = '{0, 0, 0, 0};
  always #2 clk_i = ~clk_i;
  // event counters on clock and pulse outputs
  always @(posedge clk_i) begin
    rises += (term_clk_rise_o === 1'b1);
    lows += (equip_txc_o === 1'b0) && (equip_rxc_o === 1'b0);
    pc[0] += (abort_o[0] === 1'b1);
    pc[1] += (chan_rst_o[0] === 1'b1);
    pc[2] += (rx_crc_rst_o[0] === 1'b1);
    pc[3] += (tx_crc_rst_o[0] === 1'b1);
  end
  dsc_regs i_dut (.clk_i, .rst_i, .io_addr_i, .io_rd_i, .io_wr_i,
    .io_wdata_i, .io_rdata_o, .io_rvalid_o, .irq_o, .ring_i, .dsr_a_n_i,
    .dtr_b_n_i, .cd_n_i, .cts_n_i, .ext_clk_i, .timer_a_clk_i(tclk),
    .timer_b_clk_i(tclk), .term_clk_o, .term_clk_rise_o, .equip_txc_o,
    .equip_rxc_o, .rx_valid_i, .rx_data_i, .rx_ready_o,
    .rx_parity_err_i(2'h0), .rx_frame_err_i(2'h0), .rx_break_i(2'h0),
    .tx_valid_o, .tx_data_o, .tx_ready_i, .tx_underrun_i(2'h0), .rx_ctl_o,
    .fmt_o, .tx_ctl_o, .sync_byte_o(sb), .tx_enable_o, .rts_n_o, .pin10_n_o,
    .wait_o(wt_o), .dma_req_o(), .abort_o, .rx_crc_rst_o, .tx_crc_rst_o,
    .chan_rst_o);
  dsc_far_model i_far (.clk_i, .run_i(run), .stall_i(stall),
    .rx_ready_i(rx_ready_o), .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o),
    .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i), .tx_ready_o(tx_ready_i),
    .ext_clk_o(ext_clk_i), .timer_clk_o(tclk), .last_tx_o(last_tx));
  // ==========================================================
  // bus and compare helpers
  task chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("Error at %0t ns: saw %h wanted %h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    io_addr_i <= a;
    io_wdata_i <= d;
    io_wr_i <= 1'b1;
    @(posedge clk_i);
    io_wr_i <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clk_i);
    io_addr_i <= a;
    io_rd_i <= 1'b1;
    @(posedge clk_i);
    io_rd_i <= 1'b0;
    #1 got = io_rdata_o;
  endtask
  task wreg(input logic [7:0] a, input logic [2:0] i, input logic [7:0] v);
    wr(a, {13'h0000, i});
    wr(a, {8'h00, v});
  endtask
  task wt(input int c);
    repeat (c) @(posedge clk_i);
  endtask
  // ==========================================================
  // scenarios
  task t_cmds;
    for (k = 1; k < 8; k++) wr(8'h44, 16'(k << 3));
    for (k = 1; k < 4; k++) wr(8'h44, 16'(k << 6));
    wt(4);
    chk(pc[0], 1);
    chk(pc[1], 1);
    chk(pc[2], 1);
    chk(pc[3], 1);
  endtask
  task t_board;
    ring_i <= 1'b1;
    wt(6);
    ring_i <= 1'b0;
    wt(6);
    rd(8'h80);
    chk(got[10:8], 3'h3);
    rd(8'hA0);
    rd(8'h80);
    chk(got[10:8], 3'h1);
  endtask
  task t_clocks;
    wr(8'h80, 16'h0000);
    wt(4);
    n = rises;
    k = lows;
    wt(40);
    chk(rises - n, 0);
    chk(lows - k, 0);
    wr(8'h80, 16'h0300);
    wt(4);
    n = rises;
    k = lows;
    wt(40);
    chk(rises - n >= 4, 1);
    chk(lows - k > 0, 1);
    wr(8'h80, 16'h0000);
    run <= 1'b1;
    wt(4);
    n = rises;
    wt(40);
    chk(rises - n >= 4, 1);
    run <= 1'b0;
  endtask
  task t_cfg;
    wreg(8'h44, 3'h4, 8'h4D);
    wreg(8'h44, 3'h2, 8'h00);
    wreg(8'h44, 3'h3, 8'hC1);
    wreg(8'h44, 3'h5, 8'h6A);
    wreg(8'h44, 3'h6, 8'h7E);
    wreg(8'h44, 3'h1, 8'hA0);
    wt(2);
    chk(fmt_o[7:0], 8'h4D);
    chk(rx_ctl_o[7:0], 8'hC1);
    chk(tx_ctl_o[7:0], 8'h6A);
    chk({tx_enable_o[0], rts_n_o[0]}, 2'h2);
    chk(sb[7:0], 8'h7E);
    chk(wt_o[0], 1'b1);
  endtask
  task t_vec;
    wreg(8'h46, 3'h2, 8'hA5);
    wr(8'h46, 16'h0002);
    rd(8'h46);
    chk(got[7:0], 8'hA5);
    rd(8'h46);
    chk(got & 16'h002D, 16'h0024);
    rd(8'h10);
    chk(got, 16'h0000);
  endtask
  task t_rx;
    wreg(8'h44, 3'h1, 8'h18);
    i_far.push(8'h3C, 1'b1);
    k = 0;
    while (irq_o !== 1'b1 && k < 50) begin
      @(posedge clk_i);
      k++;
    end
    chk(irq_o, 1'b1);
    rd(8'h44);
    chk(got[0], 1'b1);
    rd(8'h40);
    chk(got[7:0], 8'h3C);
    wt(3);
    chk(irq_o, 1'b0);
    wreg(8'h44, 3'h1, 8'h00);
    i_far.push(8'h11, 1'b1);
    i_far.push(8'h22, 1'b1);
    i_far.push(8'h33, 1'b0);
    wr(8'h44, 16'h0001);
    rd(8'h44);
    chk(got[5], 1'b1);
    rd(8'h40);
    chk(got[7:0], 8'h11);
    rd(8'h40);
    chk(got[7:0], 8'h22);
    wr(8'h44, 16'h0030);
    wr(8'h44, 16'h0001);
    rd(8'h44);
    chk(got[5], 1'b0);
  endtask
  task t_tx;
    stall <= 1'b1;
    wr(8'h40, 16'h005A);
    wt(4);
    chk(tx_valid_o[0], 1'b1);
    stall <= 1'b0;
    wt(6);
    chk(last_tx, 8'h5A);
    chk(tx_valid_o[0], 1'b0);
  endtask
  task conclude;
    $display("tests_run %0d fails %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    wt(20);
    rst_i <= 1'b0;
    wt(2);
    rd(8'h44);
    chk(got & 16'h002F, 16'h000C);
    t_cmds;
    t_board;
    t_clocks;
    t_cfg;
    t_vec;
    t_rx;
    t_tx;
    conclude;
  end
  // the whole run needs a few hundred cycles
  initial begin
    #100000;
    fails++;
    conclude;
  end
endmodule
bind dsc_regs dsc_regs_asserts i_chk (.clk_i, .rst_i, .io_addr_i, .io_rd_i,
  .io_wr_i, .io_wdata_i, .io_rdata_o, .io_rvalid_o, .equip_txc_o,
  .equip_rxc_o, .tx_valid_o, .tx_ready_i, .rts_n_o, .pin10_n_o, .rx_ready_o,
  .abort_o);
